// >>> src/framer_status_pkg.sv
/*
 * Constants for the framer status and interrupt mask block.
 * Assumes an 8-bit parallel control port with 8-bit register addresses.
 */
package framer_status_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] FRAMER_A_EVENT_MASK_ONE_ADDR = 8'h7f;
    localparam logic [7:0] FRAMER_B_EVENT_STATUS_TWO_ADDR = 8'hc1;
    localparam logic [7:0] FRAMER_B_EVENT_MASK_ONE_ADDR = 8'hff;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ************************************************************
    // Status two field positions
    // ************************************************************
    localparam int unsigned RX_MULTIFRAME_BIT = 7;
    localparam int unsigned TX_MULTIFRAME_BIT = 6;
    localparam int unsigned ONE_SECOND_BIT = 5;
    localparam int unsigned RX_LINK_FULL_BIT = 4;
    localparam int unsigned TX_LINK_EMPTY_BIT = 3;
    localparam int unsigned RX_LINK_MATCH_BIT = 2;
    localparam int unsigned RX_LINK_ABORT_BIT = 1;
    localparam logic [7:0] STATUS_TWO_USED = 8'hfe;

    // ************************************************************
    // Mask one field positions
    // ************************************************************
    localparam int unsigned LOOP_UP_BIT = 7;
    localparam int unsigned LOOP_DOWN_BIT = 6;
    localparam int unsigned TX_CLOCK_LOST_BIT = 5;
    localparam int unsigned SPARE_CODE_BIT = 4;
    localparam int unsigned RX_BLUE_BIT = 3;
    localparam int unsigned RX_YELLOW_BIT = 2;
    localparam int unsigned CARRIER_LOSS_BIT = 1;
    localparam int unsigned RX_SYNC_LOSS_BIT = 0;

    // ************************************************************
    // Link abort detection
    // ************************************************************
    localparam logic [3:0] ABORT_ONES = 4'h8;
    localparam logic [3:0] ONES_RESET = 4'h0;

    // ************************************************************
    // Port synchroniser reset: strobes idle high, rest low
    // ************************************************************
    localparam logic [18:0] PORT_SYNC_RESET = 19'h7_0000;

endpackage

// >>> src/link_monitor.sv
/*
 * Receive data link monitor: byte match against two values and
 * detection of eight consecutive ones.
 * Assumes link bits and bytes arrive as core_clk-synchronous valids.
 */
`timescale 1ns/1ps
module link_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic rx_link_bit,
    input wire logic rx_link_bit_valid,
    input wire logic [7:0] rx_link_byte,
    input wire logic rx_link_byte_valid,
    input wire logic [7:0] link_match_value_first,
    input wire logic [7:0] link_match_value_second,
    output logic match_pulse,
    output logic abort_pulse
);

    logic [3:0] ones_count;

    // ************************************************************
    // Byte match
    // ************************************************************
    // Either match value
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            match_pulse <= 1'b0;
        end else begin
            match_pulse <= rx_link_byte_valid &&
                ((rx_link_byte == link_match_value_first) ||
                 (rx_link_byte == link_match_value_second));
        end
    end

    // ************************************************************
    // Consecutive ones
    // ************************************************************
    // Eight ones abort
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ones_count <= framer_status_pkg::ONES_RESET;
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= 1'b0;
            if (rx_link_bit_valid) begin
                if (!rx_link_bit) begin
                    ones_count <= framer_status_pkg::ONES_RESET;
                end else if (ones_count != framer_status_pkg::ABORT_ONES) begin
                    ones_count <= ones_count + 4'h1;
                    abort_pulse <= (ones_count == framer_status_pkg::ABORT_ONES - 4'h1);
                end
            end
        end
    end

endmodule

// >>> src/framer_status_interrupt_masks.sv
/*
 * Framer B second status register and first interrupt masks of
 * framers A and B, reached through the parallel control port.
 * Assumes event inputs are core_clk pulses from framer logic and
 * port pins are asynchronous and held stable around each strobe.
 */
// Notes on behaviour
// - Framer B status two: seven event flags, bit 0 unassigned reads zero.
// - Bit 3 sets when the transmit link buffer empties.
// - Bit 2 sets when received link byte equals either match value.
// - Framer A mask one: per-bit enable of status one, 0 masks.
// - Framer B mask one: same layout and encoding as framer A.
// - Mask bit 7 gates loop-up, bit 6 loop-down detection.
// - Bits 5..1 gate clock loss, spare, blue, yellow, carrier loss.
// - Mask bit 0 gates receive sync loss.
`timescale 1ns/1ps
module framer_status_interrupt_masks (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic port_cs_n,
    input wire logic port_rd_n,
    input wire logic port_wr_n,
    input wire logic [7:0] port_addr,
    input wire logic [7:0] port_data_in,
    output logic [7:0] port_data_out,
    output logic port_data_oe,
    input wire logic rx_multiframe_edge,
    input wire logic tx_multiframe_edge,
    input wire logic one_second_tick,
    input wire logic rx_link_full_event,
    input wire logic tx_link_empty_event,
    input wire logic rx_link_bit,
    input wire logic rx_link_bit_valid,
    input wire logic [7:0] rx_link_byte,
    input wire logic rx_link_byte_valid,
    input wire logic [7:0] link_match_value_first,
    input wire logic [7:0] link_match_value_second,
    input wire logic [7:0] framer_a_status_one,
    input wire logic [7:0] framer_b_status_one,
    input wire logic [7:0] framer_b_mask_two,
    output logic irq_n
);

    logic [18:0] port_sync1;
    logic [18:0] port_sync2;
    logic wr_prev;
    logic rd_prev;
    logic wr_active;
    logic rd_active;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr_s;
    logic [7:0] wdata_s;
    logic [7:0] framer_a_event_mask_one;
    logic [7:0] framer_b_event_mask_one;
    logic [7:0] framer_b_event_status_two;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic [7:0] next_status;
    logic match_pulse;
    logic abort_pulse;
    logic next_irq;

    // ************************************************************
    // Port synchroniser
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_sync1 <= framer_status_pkg::PORT_SYNC_RESET;
            port_sync2 <= framer_status_pkg::PORT_SYNC_RESET;
        end else begin
            port_sync1 <= {port_cs_n, port_rd_n, port_wr_n, port_addr, port_data_in};
            port_sync2 <= port_sync1;
        end
    end

    assign wr_active = !port_sync2[18] && !port_sync2[16];
    assign rd_active = !port_sync2[18] && !port_sync2[17];
    assign addr_s = port_sync2[15:8];
    assign wdata_s = port_sync2[7:0];
    assign wr_stb = wr_active && !wr_prev;
    assign rd_stb = rd_active && !rd_prev;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
        end else begin
            wr_prev <= wr_active;
            rd_prev <= rd_active;
        end
    end

    // ************************************************************
    // Mask registers
    // ************************************************************
    // Framer A mask write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            framer_a_event_mask_one <= framer_status_pkg::MASK_RESET;
        end else if (wr_stb && addr_s == framer_status_pkg::FRAMER_A_EVENT_MASK_ONE_ADDR) begin
            framer_a_event_mask_one <= wdata_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            framer_b_event_mask_one <= framer_status_pkg::MASK_RESET;
        end else if (wr_stb && addr_s == framer_status_pkg::FRAMER_B_EVENT_MASK_ONE_ADDR) begin
            framer_b_event_mask_one <= wdata_s;
        end
    end

    // ************************************************************
    // Link monitor
    // ************************************************************
    link_monitor u_link_monitor (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rx_link_bit(rx_link_bit),
        .rx_link_bit_valid(rx_link_bit_valid),
        .rx_link_byte(rx_link_byte),
        .rx_link_byte_valid(rx_link_byte_valid),
        .link_match_value_first(link_match_value_first),
        .link_match_value_second(link_match_value_second),
        .match_pulse(match_pulse),
        .abort_pulse(abort_pulse)
    );

    // ************************************************************
    // Status two, sticky, cleared on read, set wins
    // ************************************************************
    always_comb begin
        status_set = 8'h00;
        status_set[framer_status_pkg::RX_MULTIFRAME_BIT] = rx_multiframe_edge;
        status_set[framer_status_pkg::TX_MULTIFRAME_BIT] = tx_multiframe_edge;
        status_set[framer_status_pkg::ONE_SECOND_BIT] = one_second_tick;
        status_set[framer_status_pkg::RX_LINK_FULL_BIT] = rx_link_full_event;
        status_set[framer_status_pkg::TX_LINK_EMPTY_BIT] = tx_link_empty_event;
        status_set[framer_status_pkg::RX_LINK_MATCH_BIT] = match_pulse;
        status_set[framer_status_pkg::RX_LINK_ABORT_BIT] = abort_pulse;
        status_clr = 8'h00;
        if (rd_stb && addr_s == framer_status_pkg::FRAMER_B_EVENT_STATUS_TWO_ADDR) begin
            status_clr = framer_b_event_status_two;
        end
        next_status = ((framer_b_event_status_two & ~status_clr) | status_set)
            & framer_status_pkg::STATUS_TWO_USED;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            framer_b_event_status_two <= framer_status_pkg::STATUS_RESET;
        end else begin
            framer_b_event_status_two <= next_status;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_data_out <= framer_status_pkg::RDATA_RESET;
            port_data_oe <= 1'b0;
        end else begin
            port_data_oe <= rd_active;
            if (rd_stb) begin
                unique case (addr_s)
                    framer_status_pkg::FRAMER_A_EVENT_MASK_ONE_ADDR:
                        port_data_out <= framer_a_event_mask_one;
                    framer_status_pkg::FRAMER_B_EVENT_STATUS_TWO_ADDR:
                        port_data_out <= framer_b_event_status_two;
                    framer_status_pkg::FRAMER_B_EVENT_MASK_ONE_ADDR:
                        port_data_out <= framer_b_event_mask_one;
                    default:
                        port_data_out <= framer_status_pkg::RDATA_RESET;
                endcase
            end
        end
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    // Gated event sum
    assign next_irq = (|(framer_a_status_one & framer_a_event_mask_one))
        || (|(framer_b_status_one & framer_b_event_mask_one))
        || (|(framer_b_event_status_two & framer_b_mask_two
              & framer_status_pkg::STATUS_TWO_USED));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !next_irq;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence link_zero_s;
        rx_link_bit_valid && !rx_link_bit;
    endsequence

    sequence link_eight_ones_s;
        (rx_link_bit_valid && rx_link_bit) [*8];
    endsequence

    AST_STATUS_BIT0_ZERO: assert property (
        @(posedge core_clk) disable iff (sys_rst) !framer_b_event_status_two[0])
        else $error("Status two bit 0 not zero");

    AST_TX_EMPTY_SETS: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        tx_link_empty_event |=> framer_b_event_status_two[3])
        else $error("Transmit empty flag not set");

    AST_MATCH_SETS: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        rx_link_byte_valid && (rx_link_byte == link_match_value_first ||
            rx_link_byte == link_match_value_second)
        |-> ##2 framer_b_event_status_two[2])
        else $error("Link match flag not set");

    AST_MASK_A_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        wr_stb && addr_s == framer_status_pkg::FRAMER_A_EVENT_MASK_ONE_ADDR
        |=> framer_a_event_mask_one == $past(wdata_s))
        else $error("Framer A mask not written");

    AST_MASK_B_WRITE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        wr_stb && addr_s == framer_status_pkg::FRAMER_B_EVENT_MASK_ONE_ADDR
        |=> framer_b_event_mask_one == $past(wdata_s) && $stable(framer_a_event_mask_one))
        else $error("Framer B mask not written");

    AST_LOOP_UP_GATE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        framer_a_status_one[7] && framer_a_event_mask_one[7] |=> !irq_n)
        else $error("Loop-up event did not interrupt");

    AST_MID_GATE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (framer_b_status_one & framer_b_event_mask_one & 8'h3e) != 8'h00 |=> !irq_n)
        else $error("Alarm event did not interrupt");

    AST_SYNC_LOSS_GATE: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        framer_b_status_one[0] && framer_b_event_mask_one[0] |=> !irq_n)
        else $error("Sync loss did not interrupt");

    AST_ABORT_SETS: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        link_zero_s ##1 link_eight_ones_s |-> ##2 framer_b_event_status_two[1])
        else $error("Link abort flag not set");

    AST_IRQ_QUIET: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (framer_a_status_one & framer_a_event_mask_one) == 8'h00 &&
        (framer_b_status_one & framer_b_event_mask_one) == 8'h00 &&
        (framer_b_event_status_two & framer_b_mask_two) == 8'h00 |=> irq_n)
        else $error("Interrupt without enabled flag");

endmodule

// >>> dv/framer_status_interrupt_masks_test.sv
/*
 * Self-checking bench for the framer status and interrupt mask block.
 * Assumes the design files and package are compiled first.
 */
`timescale 1ns/1ps
module framer_status_interrupt_masks_test;
    logic core_clk, sys_rst, port_cs_n, port_rd_n, port_wr_n, port_data_oe, irq_n;
    logic [7:0] port_addr, port_data_in, port_data_out, lbyte, m1, m2, sa, sb, mb2, rd;
    logic [4:0] ev;
    logic lbit, lbit_v, lbyte_v;
    int n_mismatch, check_count, i, k;

    framer_status_interrupt_masks dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .port_cs_n(port_cs_n),
        .port_rd_n(port_rd_n), .port_wr_n(port_wr_n), .port_addr(port_addr),
        .port_data_in(port_data_in), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .rx_multiframe_edge(ev[4]),
        .tx_multiframe_edge(ev[3]), .one_second_tick(ev[2]),
        .rx_link_full_event(ev[1]), .tx_link_empty_event(ev[0]),
        .rx_link_bit(lbit), .rx_link_bit_valid(lbit_v), .rx_link_byte(lbyte),
        .rx_link_byte_valid(lbyte_v), .link_match_value_first(m1),
        .link_match_value_second(m2), .framer_a_status_one(sa),
        .framer_b_status_one(sb), .framer_b_mask_two(mb2), .irq_n(irq_n)
    );

    // ************************************************************
    // Clock and helpers
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic port_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        port_cs_n <= 1'b0;
        port_wr_n <= 1'b0;
        port_addr <= a;
        port_data_in <= d;
        repeat (6) @(posedge core_clk);
        port_cs_n <= 1'b1;
        port_wr_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic port_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge core_clk);
        port_cs_n <= 1'b0;
        port_rd_n <= 1'b0;
        port_addr <= a;
        for (n = 0; n < 12 && port_data_oe !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 12) begin
            n_mismatch++;
            $display("wrong value read enable expected 1 seen %b", port_data_oe);
            end_sim();
        end
        d = port_data_out;
        repeat (3) @(posedge core_clk);
        port_cs_n <= 1'b1;
        port_rd_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic ev_pulse(input logic [4:0] v);
        @(posedge core_clk);
        ev <= v;
        @(posedge core_clk);
        ev <= 5'h00;
    endtask

    task automatic link_bits(input int n, input logic b);
        @(posedge core_clk);
        lbit <= b;
        lbit_v <= 1'b1;
        repeat (n) @(posedge core_clk);
        lbit_v <= 1'b0;
    endtask

    // One zero, then n ones with no gap between them
    task automatic link_run(input int n);
        @(posedge core_clk);
        lbit <= 1'b0;
        lbit_v <= 1'b1;
        @(posedge core_clk);
        lbit <= 1'b1;
        repeat (n) @(posedge core_clk);
        lbit_v <= 1'b0;
    endtask

    task automatic link_byte(input logic [7:0] v);
        @(posedge core_clk);
        lbyte <= v;
        lbyte_v <= 1'b1;
        @(posedge core_clk);
        lbyte_v <= 1'b0;
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge core_clk);
        #1;
        check("irq_n", {7'h00, irq_n}, {7'h00, exp});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        port_cs_n = 1'b1;
        port_rd_n = 1'b1;
        port_wr_n = 1'b1;
        port_addr = 8'h00;
        port_data_in = 8'h00;
        ev = 5'h00;
        {lbit, lbit_v, lbyte_v} = 3'b000;
        {lbyte, m1, m2, sa, sb, mb2} = '0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;

        port_read(framer_status_pkg::FRAMER_A_EVENT_MASK_ONE_ADDR, rd);
        check("mask a reset", rd, 8'h00);
        port_read(framer_status_pkg::FRAMER_B_EVENT_MASK_ONE_ADDR, rd);
        check("mask b reset", rd, 8'h00);
        port_read(framer_status_pkg::FRAMER_B_EVENT_STATUS_TWO_ADDR, rd);
        check("status reset", rd, 8'h00);
        check("read enable idle", {7'h00, port_data_oe}, 8'h00);
        irq_chk(1'b1);
        $display("test reset done");

        for (k = 0; k < 2; k++) begin
            port_write(8'h7f, k ? 8'h5a : 8'ha5);
            port_write(8'hff, k ? 8'ha5 : 8'h5a);
            port_read(8'h7f, rd);
            check("mask a", rd, k ? 8'h5a : 8'ha5);
            port_read(8'hff, rd);
            check("mask b", rd, k ? 8'ha5 : 8'h5a);
        end
        port_write(8'hc1, 8'hff);
        port_read(8'hc1, rd);
        check("status write ignored", rd, 8'h00);
        port_write(8'h10, 8'hff);
        port_read(8'h10, rd);
        check("unmapped read", rd, 8'h00);
        port_write(8'h7f, 8'h00);
        port_write(8'hff, 8'h00);
        $display("test masks done");

        for (k = 0; k < 6; k++) begin
            ev_pulse(k == 5 ? 5'h1f : 5'h01 << k);
            port_read(8'hc1, rd);
            check("status event", rd, k == 5 ? 8'hf8 : 8'h08 << k);
            port_read(8'hc1, rd);
            check("status cleared", rd, 8'h00);
        end
        $display("test status done");

        @(posedge core_clk);
        m1 <= 8'h3c;
        m2 <= 8'hc3;
        for (k = 0; k < 3; k++) begin
            link_byte(k == 0 ? 8'hc3 : (k == 1 ? 8'h3c : 8'h5a));
            port_read(8'hc1, rd);
            check("link match", rd, k == 2 ? 8'h00 : 8'h04);
        end
        $display("test match done");

        link_bits(1, 1'b0);
        link_bits(7, 1'b1);
        link_bits(1, 1'b0);
        port_read(8'hc1, rd);
        check("seven ones", rd, 8'h00);
        link_run(8);
        port_read(8'hc1, rd);
        check("eight ones", rd, 8'h02);
        link_bits(1, 1'b0);
        $display("test abort done");

        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            sa <= (i < 8) ? 8'h01 << i : 8'h00;
            sb <= (i < 8) ? 8'h00 : 8'h01 << (i - 8);
            port_write(i < 8 ? 8'h7f : 8'hff, ~(8'h01 << (i % 8)));
            irq_chk(1'b1);
            port_write(i < 8 ? 8'h7f : 8'hff, 8'h01 << (i % 8));
            irq_chk(1'b0);
            port_write(i < 8 ? 8'h7f : 8'hff, 8'h00);
        end
        @(posedge core_clk);
        sa <= 8'h00;
        sb <= 8'h00;
        mb2 <= 8'h08;
        ev_pulse(5'h01);
        irq_chk(1'b0);
        port_read(8'hc1, rd);
        check("status irq source", rd, 8'h08);
        irq_chk(1'b1);
        $display("test interrupt done");
        end_sim();
    end
endmodule
